// ===== design/fault_cfg.svh
// Function
// [RULE_01] thermal warning only flags, never shuts down
// [RULE_02] thermal warning clears itself when flag drops
// [RULE_03] supply check runs only while enable high
// [RULE_04] supply fault needs persistence through filter
// [RULE_05] supply fault latches switches off till reset
// [RULE_06] level select picks supply check thresholds
// [RULE_07] two-bit fault code with wake, enable high
// [RULE_08] disabled: show only undervoltage and thermal
// [RULE_09] wake low: both code outputs undriven
// [RULE_10] short, over, supply latch; under restarts
// [RULE_11] faults never cause sleep, only wake
// [RULE_12] fixed priority: supply, short, under, over, hot
// [RULE_13] long enable low clears latches, switches off
// [RULE_14] short qualified by about 12 us filter
// [RULE_15] short integrator: 30% never, 70% trips
// [RULE_16] host holds enable low 3 us minimum
// [RULE_17] enable low 1 us or less: no reset
// [RULE_18] supply filter lasts 10 to 25 us
// [RULE_19] auto-restart resumes within 1 us
// [RULE_20] flags synchronised, filters counted in cycles
`ifndef FAULT_CFG_SVH
`define FAULT_CFG_SVH

// =====================================================
// clock and timing
// =====================================================
`define CLK_NS        50
`define SC_FILT_NS    12000
`define SC_FILT_CYC   (`SC_FILT_NS / `CLK_NS)
`define SC_UP         2
`define SC_LIMIT      (`SC_UP * `SC_FILT_CYC)
`define VC_FILT_NS    15000
`define VC_FILT_CYC   ((`VC_FILT_NS + `CLK_NS - 1) / `CLK_NS)
`define OV_FILT_NS    45000
`define OV_FILT_CYC   ((`OV_FILT_NS + `CLK_NS - 1) / `CLK_NS)
`define UV_FILT_NS    5000
`define UV_FILT_CYC   ((`UV_FILT_NS + `CLK_NS - 1) / `CLK_NS)
`define RES1_NS       3000
`define RES0_NS       1000
`define ENA_RES_CYC   (((`RES0_NS + `RES1_NS) / 2) / `CLK_NS)
`define AR_NS         1000
`define AR_CYC        (`AR_NS / `CLK_NS)

// =====================================================
// register map
// =====================================================
`define REG_STATUS    8'h00
`define REG_CTRL      8'h04
`define CTRL_RESET    32'h0000_0001
`define CTRL_SCD_EN   0
`define ST_SUPPLY     0
`define ST_SHORT      1
`define ST_UNDER      2
`define ST_OVER       3
`define ST_HOT        4
`define ST_SHUT       5
`define ST_CODE_LO    6
`define ST_CODE_HI    7

`endif

// ===== design/fault_pkg.sv
package fault_pkg;

    // two-bit fault code as seen on the pins {a,b}
    typedef enum logic [1:0] {
        CODE_SUPPLY = 2'b00, // under voltage or supply check
        CODE_HOT    = 2'b01, // thermal or over voltage
        CODE_SHORT  = 2'b10, // short circuit
        CODE_NONE   = 2'b11  // nothing to report
    } code_t;

    // one bit per fault class
    typedef struct packed {
        logic supply;
        logic short_c;
        logic under;
        logic over;
        logic hot;
    } flags_t;

endpackage : fault_pkg

// ===== design/fault_filter.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================
// persistence filter / leaky integrator
// =====================================================
// leak 0: count resets when input drops (plain filter)
// leak 1: count decays by one per idle cycle
module fault_filter #(
    parameter int W     = 10,
    parameter int LIMIT = 300,
    parameter int UP    = 1,
    parameter bit LEAK  = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic clear_i,  // force count to zero
    input  wire logic active_i, // condition present
    output logic      hit_o     // qualified condition
);
    logic [W-1:0] cnt;           // charge level
    logic [W-1:0] next_cnt;

    localparam logic [W-1:0] LIM = W'(LIMIT);
    localparam logic [W-1:0] INC = W'(UP);

    // saturate at the limit so the count never wraps
    wire          at_lim = (cnt >= LIM);
    wire [W-1:0]  up_val = at_lim ? LIM : cnt + INC;
    wire [W-1:0]  dn_val = (LEAK && cnt != '0) ? cnt - 1'b1
                                              : '0;

    always_comb begin
        // clear beats everything
        if (clear_i) begin
            next_cnt = '0;
        end else if (active_i) begin
            next_cnt = up_val;
        end else begin
            next_cnt = dn_val;
        end
    end

    // counter register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign hit_o = at_lim;

endmodule : fault_filter

`default_nettype wire

// ===== design/bridge_fault_reporter.sv
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "fault_cfg.svh"

// =====================================================
// fault collection, latching and reporting
// =====================================================
module bridge_fault_reporter #(
    parameter int PH = 3,   // half bridges
    parameter int CW = 10   // filter counter width
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // classic wishbone slave
    input  wire logic          cyc_i,
    input  wire logic          stb_i,
    input  wire logic          we_i,
    input  wire logic [7:0]    adr_i,
    input  wire logic [3:0]    sel_i,
    input  wire logic [31:0]   dat_i,
    output logic [31:0]        dat_o,
    output logic               ack_o,
    // host control pins
    input  wire logic          bridge_enable_input_i,
    input  wire logic          wake_control_input_i,
    input  wire logic          supply_check_level_select_i,
    // switching commands
    input  wire logic [PH-1:0] high_side_command_inputs_i,
    input  wire logic [PH-1:0] low_side_command_inputs_i,
    // comparator flags, asynchronous
    input  wire logic [PH-1:0] short_circuit_detect_i,
    input  wire logic          supply_under_i,
    input  wire logic          supply_over_low_i,
    input  wire logic          supply_over_high_i,
    input  wire logic          bank_under_i,
    input  wire logic          bank_over_i,
    input  wire logic          thermal_warning_i,
    // gate commands to the output stages
    output logic [PH-1:0]      gate_high_o,
    output logic [PH-1:0]      gate_low_o,
    // fault code pins, push-pull with enable
    output logic               fault_code_out_a_o,
    output logic               fault_code_out_a_oe_o,
    output logic               fault_code_out_b_o,
    output logic               fault_code_out_b_oe_o
);

    // =================================================
    // flag synchronisers
    // =================================================
    localparam int NS = PH + 6;
    wire  [NS-1:0] raw = {short_circuit_detect_i,
                          supply_under_i, supply_over_low_i,
                          supply_over_high_i, bank_under_i,
                          bank_over_i, thermal_warning_i};
    logic [NS-1:0] meta;   // first stage, read only by sync
    logic [NS-1:0] sync;   // second stage, safe to use

    // two flops per flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            sync <= '0;
        end else begin
            meta <= raw;   // RULE_20
            sync <= meta;  // RULE_20
        end
    end

    wire [PH-1:0] sc_s  = sync[NS-1:6];
    wire          vu_s  = sync[5];   // supply under
    wire          vlo_s = sync[4];   // supply over, low level set
    wire          vhi_s = sync[3];   // supply over, high level set
    wire          uv_s  = sync[2];
    wire          ov_s  = sync[1];
    wire          ot_s  = sync[0];

    wire en   = bridge_enable_input_i;
    wire wake = wake_control_input_i;

    // =================================================
    // registers and enable reset timer
    // =================================================
    logic [31:0]          ctrl;     // software control
    logic [7:0]           ena_cnt;  // enable low duration
    fault_pkg::flags_t    lat;      // latched faults
    fault_pkg::flags_t    next_lat;
    logic                 run;      // switches may follow
    fault_pkg::code_t     code;     // registered code

    localparam logic [7:0] ENA_N = 8'(`ENA_RES_CYC);

    // reset request once enable has been low long enough
    wire ena_clr = (ena_cnt >= ENA_N);   // RULE_13 RULE_17

    // count enable low time, saturating
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ena_cnt <= 8'h00;
        end else if (en) begin
            ena_cnt <= 8'h00;
        end else if (!ena_clr) begin
            ena_cnt <= ena_cnt + 8'h01;
        end
    end

    // =================================================
    // filters
    // =================================================
    wire          scd_en = ctrl[`CTRL_SCD_EN];
    logic [PH-1:0] sc_hit;   // per-bridge integrator trip
    logic          vc_hit;
    logic          ov_hit;
    logic          uv_hit;

    // supply check: level select picks the over threshold
    wire vc_over = supply_check_level_select_i ? vhi_s
                                               : vlo_s;  // RULE_06
    wire vc_bad  = vu_s | vc_over;

    // shared charge per half bridge, discharge at half rate
    // so a 30% duty loses ground and 70% builds up
    genvar g;
    generate
        for (g = 0; g < PH; g++) begin : g_sc
            fault_filter #(
                .W      (CW),
                .LIMIT  (`SC_LIMIT),
                .UP     (`SC_UP),
                .LEAK   (1'b1)
            ) u_sc (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .clear_i  (!scd_en),
                .active_i (sc_s[g] & scd_en), // RULE_14 RULE_15
                .hit_o    (sc_hit[g])
            );
        end
    endgenerate

    // supply check only counts while enabled
    fault_filter #(
        .W      (CW),
        .LIMIT  (`VC_FILT_CYC),
        .UP     (1),
        .LEAK   (1'b0)
    ) u_vc (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .clear_i  (!en),               // RULE_03
        .active_i (vc_bad),            // RULE_04 RULE_18
        .hit_o    (vc_hit)
    );

    // bank over voltage
    fault_filter #(
        .W      (CW),
        .LIMIT  (`OV_FILT_CYC),
        .UP     (1),
        .LEAK   (1'b0)
    ) u_ov (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .clear_i  (1'b0),
        .active_i (ov_s),
        .hit_o    (ov_hit)
    );

    // bank under voltage; drops at once when recovered
    fault_filter #(
        .W      (CW),
        .LIMIT  (`UV_FILT_CYC),
        .UP     (1),
        .LEAK   (1'b0)
    ) u_uv (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .clear_i  (1'b0),
        .active_i (uv_s),
        .hit_o    (uv_hit)
    );

    // =================================================
    // latches and shutdown
    // =================================================
    // a new set wins over the enable reset
    always_comb begin
        next_lat         = lat;
        next_lat.supply  = vc_hit | (lat.supply & !ena_clr);
        next_lat.short_c = (|sc_hit)
                         | (lat.short_c & !ena_clr); // RULE_10
        next_lat.over    = ov_hit | (lat.over & !ena_clr);
        next_lat.under   = uv_hit;   // RULE_10 auto restart
        next_lat.hot     = ot_s;     // RULE_02 self clearing
    end

    // hot is a warning only and stays out of the shutdown
    wire shut = next_lat.supply | next_lat.short_c  // RULE_05
              | next_lat.over | next_lat.under      // RULE_10
              | !en | !wake;                        // RULE_01 RULE_13

    // no fault touches wake; sleep follows the pin only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lat <= '0;
            run <= 1'b0;
        end else begin
            lat <= next_lat;
            run <= !shut;             // RULE_11 RULE_19
        end
    end

    // both sides on at once is ignored, not reported
    wire [PH-1:0] clash = high_side_command_inputs_i
                        & low_side_command_inputs_i;

    // gate drive, off whenever not running
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gate_high_o <= '0;
            gate_low_o  <= '0;
        end else begin
            gate_high_o <= run ? high_side_command_inputs_i
                               & ~clash : '0;   // RULE_19
            gate_low_o  <= run ? low_side_command_inputs_i
                               & ~clash : '0;
        end
    end

    // =================================================
    // fault code encoding
    // =================================================
    // priority chain; disable masks all but under and hot
    function automatic fault_pkg::code_t enc(
        input fault_pkg::flags_t f,
        input logic              enabled
    );
        if (!enabled) begin
            if (f.under) begin
                enc = fault_pkg::CODE_SUPPLY;   // RULE_08
            end else if (f.hot) begin
                enc = fault_pkg::CODE_HOT;
            end else begin
                enc = fault_pkg::CODE_NONE;
            end
        end else if (f.supply | f.under) begin
            // supply check ranks above short; under below it
            enc = f.supply ? fault_pkg::CODE_SUPPLY
                : (f.short_c ? fault_pkg::CODE_SHORT
                             : fault_pkg::CODE_SUPPLY);
        end else if (f.short_c) begin
            enc = fault_pkg::CODE_SHORT;        // RULE_12
        end else if (f.over | f.hot) begin
            enc = fault_pkg::CODE_HOT;          // RULE_07
        end else begin
            enc = fault_pkg::CODE_NONE;
        end
    endfunction : enc

    wire fault_pkg::code_t next_code = enc(lat, en);

    // pins undriven while asleep; pull-downs read low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code                  <= fault_pkg::CODE_NONE;
            fault_code_out_a_oe_o <= 1'b0;
            fault_code_out_b_oe_o <= 1'b0;
        end else begin
            code                  <= next_code;
            fault_code_out_a_oe_o <= wake;      // RULE_09
            fault_code_out_b_oe_o <= wake;
        end
    end

    assign fault_code_out_a_o = fault_code_out_a_oe_o & code[1];
    assign fault_code_out_b_o = fault_code_out_b_oe_o & code[0];

    // =================================================
    // wishbone slave
    // =================================================
    // one wait state: ack a cycle after strobe, writes land
    // on the edge where the master samples ack
    wire        req    = cyc_i & stb_i;
    wire        hit_st = (adr_i == `REG_STATUS);
    wire        hit_ct = (adr_i == `REG_CTRL);
    wire        wr_ct  = req & we_i & ack_o & hit_ct & sel_i[0];
    wire [31:0] st_val = {24'h000000, code,
                          !run, lat.hot, lat.over,
                          lat.under, lat.short_c, lat.supply};
    // unmapped reads return zero, writes are dropped
    wire [31:0] rd_mux = hit_st ? st_val
                       : (hit_ct ? ctrl : 32'h0000_0000);

    // ack, read data and control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            ctrl  <= `CTRL_RESET;
        end else begin
            ack_o <= req & !ack_o;
            dat_o <= rd_mux;
            if (wr_ct) begin
                ctrl <= {24'h000000, 7'h00, dat_i[0]};
            end
        end
    end

    // =================================================
    // checks
    // =================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    localparam int VC_MIN = 200;
    logic [15:0] vc_run;  // consecutive enabled bad cycles
    logic [15:0] sc_run;  // consecutive short on bridge 0
    logic [15:0] en_low;  // consecutive enable low cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vc_run <= 16'h0000;
            sc_run <= 16'h0000;
            en_low <= 16'h0000;
        end else begin
            vc_run <= (vc_bad & en) ? vc_run + 16'h0001
                                    : 16'h0000;
            sc_run <= (sc_s[0] & scd_en) ? sc_run + 16'h0001
                                         : 16'h0000;
            en_low <= en ? 16'h0000 : en_low + 16'h0001;
        end
    end

    AST_HOT_NO_SHUT: assert property ( // RULE_01
        en && wake && lat == '0 && next_lat == 5'b00001
        |=> run) else $error("thermal warning shut down");
    AST_HOT_CLEARS: assert property ( // RULE_02
        $fell(ot_s) |=> !lat.hot)
        else $error("thermal warning stuck");
    AST_VC_IDLE: assert property ( // RULE_03
        !en ##1 !en |-> !vc_hit)
        else $error("supply check active while disabled");
    AST_VC_FILTER: assert property ( // RULE_04 RULE_18
        $rose(lat.supply) |-> $past(vc_run) >= VC_MIN)
        else $error("supply fault without persistence");
    AST_VC_LATCH: assert property ( // RULE_05
        lat.supply && !ena_clr |=> lat.supply ##1 !run)
        else $error("supply latch lost");
    AST_LEVEL_SEL: assert property ( // RULE_06
        supply_check_level_select_i && !vhi_s && !vu_s
        |-> !vc_bad) else $error("wrong threshold set");
    AST_CODE_SUPPLY: assert property ( // RULE_07 RULE_12
        wake && en && lat.supply |=> code == 2'b00)
        else $error("supply code wrong");
    AST_CODE_SHORT: assert property ( // RULE_12
        wake && en && lat.short_c && !lat.supply
        |=> code == 2'b10) else $error("short code wrong");
    AST_DISABLE_MASK: assert property ( // RULE_08
        wake && !en && !lat.under && !lat.hot
        |=> code == 2'b11) else $error("masked fault shown");
    AST_SLEEP_HIZ: assert property ( // RULE_09
        !wake |=> !fault_code_out_a_oe_o && !fault_code_out_a_o
                  && !fault_code_out_b_oe_o)
        else $error("code pins driven in sleep");
    AST_LATCH_SHUT: assert property ( // RULE_10
        lat.short_c || lat.over |=> gate_high_o == '0
        && gate_low_o == '0) else $error("switch on at fault");
    AST_NO_SLEEP: assert property ( // RULE_11
        wake ##1 wake ##1 wake |-> fault_code_out_b_oe_o)
        else $error("fault caused sleep");
    AST_ENA_CLEAR: assert property ( // RULE_13
        ena_clr && !vc_hit && !(|sc_hit) && !ov_hit
        |=> !lat.supply && !lat.short_c && !lat.over)
        else $error("enable reset failed");
    AST_SC_TRIP: assert property ( // RULE_14
        sc_run == 16'd330 |-> lat.short_c)
        else $error("static short not latched in time");
    AST_SHORT_PULSE: assert property ( // RULE_17
        en_low <= 16'd20 |-> !ena_clr)
        else $error("short enable pulse reset");
    AST_RESTART: assert property ( // RULE_19
        $fell(lat.under) && lat == '0 && en && wake
        ##1 (lat == '0 && en && wake)[*2] |-> run)
        else $error("no auto restart");
    AST_SYNC: assert property ( // RULE_20
        ##2 ot_s == $past(thermal_warning_i, 2))
        else $error("flag not synchronised");

    COV_SHORT:   cover property ($rose(lat.short_c));
    COV_SUPPLY:  cover property ($rose(lat.supply));
    COV_RESET:   cover property ($rose(ena_clr) ##1 lat == '0);
    COV_RESTART: cover property ($fell(lat.under) ##[1:4] run);

endmodule : bridge_fault_reporter

`default_nettype wire

// ===== tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================
// host side: drives enable and wake, reads code pins
// =====================================================
module host_model (
    input  wire logic       clk_i,
    input  wire logic       a_i,    // code bit a
    input  wire logic       a_oe_i, // bit a driven
    input  wire logic       b_i,    // code bit b
    input  wire logic       b_oe_i, // bit b driven
    output logic            en_o,   // bridge enable
    output logic            wake_o, // wake, low = sleep
    output logic [1:0]      code_o  // level seen on the pins
);
    // released pins settle at the pull-down level
    assign code_o = {a_oe_i & a_i, b_oe_i & b_i};

    // host powers up awake and enabled
    initial begin
        en_o   = 1'b1;
        wake_o = 1'b1;
    end

    // set both control pins, called just after an edge
    task automatic set(input logic en, input logic wk);
        en_o   <= en;
        wake_o <= wk;
    endtask : set

    // enable low for n cycles; 60 keeps a safe margin
    task automatic pulse(input int n);
        en_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        en_o <= 1'b1;
        // let one edge pass so a following call never
        // drives enable twice in the same time step
        @(posedge clk_i);
    endtask : pulse
endmodule : host_model

`default_nettype wire

// ===== tb/bridge_fault_reporter_tb.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================
// self-checking bench
// =====================================================
module bridge_fault_reporter_tb;
    logic        clk_i, rst_i, cyc, stb, we, lvl;  // bus and select
    logic [7:0]  adr;                              // byte address
    logic [3:0]  sel;                              // byte lanes
    logic [31:0] dat, rdat;                        // bus data
    logic        ack, a, a_oe, b, b_oe, en, wake;  // pins
    logic [2:0]  hi, lo, short_circuit_detect, gh, gl;              // bridges
    logic        s_un, s_lo, s_hi, b_un, b_ov, hot; // flags
    logic [1:0]  code;                             // host view
    int          err_total, check_count;           // tallies

    bridge_fault_reporter bridge_fault_reporter_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
        .dat_o(rdat), .ack_o(ack), .bridge_enable_input_i(en),
        .wake_control_input_i(wake),
        .supply_check_level_select_i(lvl),
        .high_side_command_inputs_i(hi),
        .low_side_command_inputs_i(lo),
        .short_circuit_detect_i(short_circuit_detect), .supply_under_i(s_un),
        .supply_over_low_i(s_lo), .supply_over_high_i(s_hi),
        .bank_under_i(b_un), .bank_over_i(b_ov),
        .thermal_warning_i(hot), .gate_high_o(gh), .gate_low_o(gl),
        .fault_code_out_a_o(a), .fault_code_out_a_oe_o(a_oe),
        .fault_code_out_b_o(b), .fault_code_out_b_oe_o(b_oe));

    host_model host_model_inst (
        .clk_i(clk_i), .a_i(a), .a_oe_i(a_oe), .b_i(b),
        .b_oe_i(b_oe), .en_o(en), .wake_o(wake), .code_o(code));

    // 20 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // verdict in one place
    task automatic complete_run();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // bounded wait for a code; a miss ends the run
    task automatic wait_code(input logic [1:0] e, input int lim);
        int n;
        n = 0;
        while (code !== e && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        check(code, e);
        if (code !== e) complete_run();
    endtask : wait_code

    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] ad,
                      input logic [3:0] s, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        {cyc, stb, we, adr, sel, dat} <= {2'h3, w, ad, s, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        {cyc, stb} <= 2'h0;
        @(posedge clk_i);
        if (n >= 50) begin
            err_total++;
            complete_run();
        end
    endtask : wb

    task automatic t_regs();
        logic [31:0] q;
        wb(1'b0, 8'h04, 4'hf, 32'h0, q);
        check(q, 32'h1);
        wb(1'b1, 8'h04, 4'hf, 32'h0, q);    // protection off
        wb(1'b0, 8'h04, 4'hf, 32'h0, q);
        check(q, 32'h0);
        wb(1'b1, 8'h04, 4'hf, 32'h1, q);    // protection back on
        wb(1'b0, 8'h04, 4'hf, 32'h0, q);
        check(q, 32'h1);
        wb(1'b0, 8'h00, 4'hf, 32'h0, q);
        check(q, 32'hc0);
        wb(1'b1, 8'h10, 4'hf, 32'h0, q);    // unmapped: ignored
        wb(1'b0, 8'h10, 4'hf, 32'h0, q);
        check(q, 32'h0);
    endtask : t_regs

    task automatic t_short();
        short_circuit_detect <= 3'h1;
        tick(200);
        check(code, 2'h3);
        wait_code(2'h2, 130);
        tick(3);
        check({a_oe, b_oe, gh}, 5'h18);
        short_circuit_detect <= 3'h0;
        host_model_inst.pulse(20);
        check(code, 2'h3);
        wait_code(2'h2, 10);
        host_model_inst.pulse(60);
        tick(5);
        check({code, gh}, 5'h1d);
    endtask : t_short

    // six periods of a 100 kHz duty pattern on the bridge 1 short flag
    task automatic t_duty(input int on);
        repeat (6) begin
            short_circuit_detect <= 3'h2;
            tick(on);
            short_circuit_detect <= 3'h0;
            tick(200 - on);
        end
    endtask : t_duty

    task automatic t_supply();
        host_model_inst.set(1'b0, 1'b1);
        s_lo <= 1'b1;
        tick(400);
        host_model_inst.set(1'b1, 1'b1);
        tick(190);
        check(code, 2'h3);
        wait_code(2'h0, 320);
        s_lo <= 1'b0;
        short_circuit_detect <= 3'h4;
        tick(300);
        check({code, gl}, 5'h0);
        short_circuit_detect <= 3'h0;
        host_model_inst.pulse(60);
        {lvl, s_lo} <= 2'h3;
        tick(600);
        check(code, 2'h3);
        {s_lo, s_hi} <= 2'h1;
        wait_code(2'h0, 600);
        {lvl, s_hi} <= 2'h0;
        host_model_inst.pulse(60);
        tick(5);
    endtask : t_supply

    task automatic t_under();
        b_un <= 1'b1;
        wait_code(2'h0, 150);
        tick(3);
        check(gh, 3'h0);
        b_un <= 1'b0;
        {hi, lo} <= 6'h15;
        tick(20);
        check({code, gl}, 5'h1d);
        host_model_inst.set(1'b0, 1'b1);
        b_un <= 1'b1;
        wait_code(2'h0, 150);
        {b_un, hot} <= 2'h1;
        wait_code(2'h1, 150);
        hot <= 1'b0;
        host_model_inst.set(1'b1, 1'b0);
        tick(3);
        check({a_oe, b_oe, code}, 4'h0);
        host_model_inst.set(1'b1, 1'b1);
        wait_code(2'h3, 150);
    endtask : t_under

    // bank over voltage latches until an enable reset
    task automatic t_over();
        b_ov <= 1'b1;
        wait_code(2'h1, 950);
        b_ov <= 1'b0;
        tick(20);
        check({code, gh}, 5'h08);
        host_model_inst.pulse(60);
        wait_code(2'h3, 10);
    endtask : t_over

    // main sequence; commands fixed until the restart test
    initial begin
        {cyc, stb, we, lvl, s_un, s_lo, s_hi, b_un, b_ov, hot} = '0;
        {adr, sel, dat, short_circuit_detect} = '0;
        {hi, lo} = 6'h2a;
        {err_total, check_count} = '0;
        rst_i = 1'b1;
        tick(4);
        rst_i <= 1'b0;
        tick(1);
        t_regs();
        hot <= 1'b1;
        wait_code(2'h1, 20);
        check(gh, 3'h5);
        hot <= 1'b0;
        wait_code(2'h3, 20);
        t_short();
        t_duty(60);
        check(code, 2'h3);
        t_duty(140);
        check(code, 2'h2);
        host_model_inst.pulse(60);
        t_supply();
        t_under();
        t_over();
        complete_run();
    end
endmodule : bridge_fault_reporter_tb

`default_nettype wire
